//--- hw/rxpd_detector.sv
// preamble detector with invalid-preamble flag and ahb-lite register slave
//
// Our own choice: the AHB-Lite register port.
`timescale 1ns/10ps
module rxpd_detector
  import rxpd_pkg::*;
#(
  parameter int SYNC_WAIT_BITS = 32,
  parameter int CW             = 8
) (
  // clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // demodulated bit stream
  input  wire logic        bit_valid,
  input  wire logic        bit_data,
  input  wire logic        sync_found,
  // pins and status
  output logic             gpio_out,
  output logic             irq,
  output logic             preamble_detect,
  output logic             invalid_preamble_flag,
  output logic [8:0]       tx_preamble_len,
  output logic [2:0]       ant_div_mode
);

  typedef enum logic [2:0] {RXPD_ST_OFF, RXPD_ST_SETTLE, RXPD_ST_SEARCH,
                            RXPD_ST_FOUND, RXPD_ST_LOCKED} rxpd_state_t;
  localparam logic [CW-1:0] BLANK_CNT = CW'(RXPD_BLANK_BITS);
  localparam logic [CW-1:0] SYNC_CNT  = CW'(SYNC_WAIT_BITS);
  function automatic logic [7:0] rxpd_idx(input logic [31:0] addr);
    rxpd_idx = addr[9:2];
  endfunction : rxpd_idx
  rxpd_state_t   state_ff;
  rxpd_state_t   nxt_state;
  logic [CW-1:0] bitcnt_ff;
  logic [CW-1:0] nxt_bitcnt;
  logic [7:0]  opfunc_ff;
  logic [7:0]  hdr_ctrl_ff;
  logic [7:0]  prea_len_ff;
  logic [7:0]  prea_thresh_ff;
  logic [7:0]  irq_mask_ff;
  logic [7:0]  rx_ctrl_ff;
  logic [7:0]  status_ff;
  logic [7:0]  nxt_status;
  logic        wr_pend_ff;
  logic        rd_pend_ff;
  logic [7:0]  idx_ff;
  logic        hreadyout_ff;
  logic [31:0] hrdata_ff;
  logic        valid_ff;
  logic        invalid_ff;
  logic        gpio_ff;
  logic        irq_ff;
  logic          rx_en;
  logic          clear_run;
  logic          run_hit;
  logic          mismatch;
  logic [CW-1:0] run_need;
  logic          set_valid;
  logic          set_invalid;
  logic          wr_go;
  logic [7:0]    wbyte;
  logic          addr_ok;
  logic [7:0]    rmux;

  assign rx_en = rx_ctrl_ff[RXPD_BIT_RX_ENABLE];
  assign run_need = CW'(prea_thresh_ff[7:RXPD_THRESH_LSB]) * CW'(RXPD_THRESH_STEP_BITS);
  assign clear_run = (state_ff != RXPD_ST_SEARCH) && (state_ff != RXPD_ST_SETTLE);

  rxpd_run_counter #(
    .CW (CW)
  ) u_run (
    .hclk      (hclk),
    .hresetn   (hresetn),
    .clear     (clear_run),
    .run_need  (run_need),
    .bit_valid (bit_valid),
    .bit_data  (bit_data),
    .run_hit   (run_hit),
    .mismatch  (mismatch)
  );

  // detector sequence, one bit period at a time
  always_comb
  begin
    nxt_state  = state_ff;
    nxt_bitcnt = bitcnt_ff;
    case (state_ff)
      RXPD_ST_OFF:
      begin
        nxt_bitcnt = '0;
        if (rx_en)
          nxt_state = RXPD_ST_SETTLE;
      end
      RXPD_ST_SETTLE:
      begin
        if (bit_valid)
        begin
          nxt_bitcnt = bitcnt_ff + 1'b1;
          if (bitcnt_ff == BLANK_CNT - 1'b1)
            nxt_state = RXPD_ST_SEARCH;
        end
      end
      RXPD_ST_SEARCH:
      begin
        nxt_bitcnt = '0;
        if (run_hit)
          nxt_state = RXPD_ST_FOUND;
      end
      RXPD_ST_FOUND:
      begin
        if (sync_found)
          nxt_state = RXPD_ST_LOCKED;
        else if (bit_valid)
        begin
          nxt_bitcnt = bitcnt_ff + 1'b1;
          if (bitcnt_ff == SYNC_CNT - 1'b1)
            nxt_state = RXPD_ST_SEARCH;
        end
      end
      RXPD_ST_LOCKED: nxt_bitcnt = '0;
      default:
      begin
        nxt_state  = RXPD_ST_OFF;
        nxt_bitcnt = '0;
      end
    endcase
    if (!rx_en)
    begin
      nxt_state  = RXPD_ST_OFF;
      nxt_bitcnt = '0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_ff  <= RXPD_ST_OFF;
      bitcnt_ff <= '0;
    end
    else
    begin
      state_ff  <= nxt_state;
      bitcnt_ff <= nxt_bitcnt;
    end
  end

  // live flags; invalid stays up until a valid run or the receiver stops
  assign set_valid   = (state_ff == RXPD_ST_SEARCH) && run_hit && rx_en;
  assign set_invalid = (state_ff == RXPD_ST_SEARCH) && mismatch && !invalid_ff && rx_en;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      valid_ff   <= 1'b0;
      invalid_ff <= 1'b0;
    end
    else
    begin
      valid_ff <= (nxt_state == RXPD_ST_FOUND) || (nxt_state == RXPD_ST_LOCKED);
      if (nxt_state != RXPD_ST_SEARCH)
        invalid_ff <= 1'b0;
      else if (set_invalid)
        invalid_ff <= 1'b1;
    end
  end

  // bus: writes take no wait, reads take one so the data reflect any write before
  assign wr_go = wr_pend_ff;
  assign wbyte = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_ff   <= 1'b0;
      rd_pend_ff   <= 1'b0;
      idx_ff       <= 8'h00;
      hreadyout_ff <= 1'b1;
    end
    else
    begin
      wr_pend_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      if (rd_pend_ff)
        hreadyout_ff <= 1'b1;
      else if (hsel && hready && (htrans == RXPD_HTRANS_NONSEQ))
      begin
        idx_ff     <= rxpd_idx(haddr);
        wr_pend_ff <= hwrite;
        rd_pend_ff <= !hwrite;
        if (!hwrite)
          hreadyout_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      opfunc_ff      <= RXPD_RST_OPFUNC_SECOND;
      hdr_ctrl_ff    <= RXPD_RST_HDR_CTRL_SEC;
      prea_len_ff    <= RXPD_RST_PREA_LEN;
      prea_thresh_ff <= RXPD_RST_PREA_THRESH;
      irq_mask_ff    <= RXPD_RST_IRQ_MASK;
      rx_ctrl_ff     <= RXPD_RST_RX_CONTROL;
    end
    else if (wr_go)
      case (idx_ff)
        RXPD_IDX_OPFUNC_SECOND: opfunc_ff      <= wbyte;
        RXPD_IDX_HDR_CTRL_SEC:  hdr_ctrl_ff    <= wbyte & RXPD_HDR_MASK;
        RXPD_IDX_PREA_LEN:      prea_len_ff    <= wbyte;
        RXPD_IDX_PREA_THRESH:   prea_thresh_ff <= wbyte & RXPD_THRESH_MASK;
        RXPD_IDX_IRQ_MASK:      irq_mask_ff    <= wbyte & RXPD_EVENT_MASK;
        RXPD_IDX_RX_CONTROL:    rx_ctrl_ff     <= wbyte & RXPD_CTRL_MASK;
        default:                rx_ctrl_ff     <= rx_ctrl_ff;
      endcase
  end

  // sticky events; a new event wins over a write-one clear in the same cycle
  always_comb
  begin
    nxt_status = status_ff;
    if (wr_go && (idx_ff == RXPD_IDX_STATUS_FIRST))
      nxt_status = status_ff & ~(wbyte & RXPD_EVENT_MASK);
    if (set_valid)
      nxt_status[RXPD_BIT_VALID] = 1'b1;
    if (set_invalid)
      nxt_status[RXPD_BIT_INVALID] = 1'b1;
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      status_ff <= 8'h00;
    else
      status_ff <= nxt_status;
  end

  always_comb
  begin
    addr_ok = 1'b1;
    rmux    = 8'h00;
    case (idx_ff)
      RXPD_IDX_STATUS_FIRST:  rmux = status_ff;
      RXPD_IDX_STATUS_SECOND: rmux = {5'h00, (state_ff == RXPD_ST_SETTLE),
                                      invalid_ff, valid_ff};
      RXPD_IDX_IRQ_MASK:      rmux = irq_mask_ff;
      RXPD_IDX_RX_CONTROL:    rmux = rx_ctrl_ff;
      RXPD_IDX_OPFUNC_SECOND: rmux = opfunc_ff;
      RXPD_IDX_HDR_CTRL_SEC:  rmux = hdr_ctrl_ff;
      RXPD_IDX_PREA_LEN:      rmux = prea_len_ff;
      RXPD_IDX_PREA_THRESH:   rmux = prea_thresh_ff;
      default:                addr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata_ff <= 32'h0000_0000;
    else if (rd_pend_ff)
      hrdata_ff <= addr_ok ? {24'h00_0000, rmux} : 32'h0000_0000;
  end

  // pin and interrupt outputs
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      gpio_ff <= 1'b0;
      irq_ff  <= 1'b0;
    end
    else
    begin
      case (rxpd_gpio_sel_t'(rx_ctrl_ff[RXPD_GPIO_SEL_LSB +: 2]))
        RXPD_GPIO_VALID:   gpio_ff <= valid_ff;
        RXPD_GPIO_INVALID: gpio_ff <= invalid_ff;
        RXPD_GPIO_HIGH:    gpio_ff <= 1'b1;
        default:           gpio_ff <= 1'b0;
      endcase
      irq_ff <= |(nxt_status & irq_mask_ff & RXPD_EVENT_MASK);
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_preamble_len <= {RXPD_RST_HDR_CTRL_SEC[RXPD_HDR_PREA_MSB], RXPD_RST_PREA_LEN};
      ant_div_mode    <= RXPD_RST_OPFUNC_SECOND[RXPD_ANTDIV_LSB +: 3];
    end
    else
    begin
      tx_preamble_len <= {hdr_ctrl_ff[RXPD_HDR_PREA_MSB], prea_len_ff};
      ant_div_mode    <= opfunc_ff[RXPD_ANTDIV_LSB +: 3];
    end
  end

  assign hreadyout             = hreadyout_ff;
  assign hresp                 = 1'b0;
  assign hrdata                = hrdata_ff;
  assign gpio_out              = gpio_ff;
  assign irq                   = irq_ff;
  assign preamble_detect       = valid_ff;
  assign invalid_preamble_flag = invalid_ff;

endmodule : rxpd_detector

//--- hw/rxpd_pkg.sv
// constants shared by the receive preamble detector files
package rxpd_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0] RXPD_IDX_STATUS_FIRST  = 8'h03;
  localparam logic [7:0] RXPD_IDX_STATUS_SECOND = 8'h04;
  localparam logic [7:0] RXPD_IDX_IRQ_MASK      = 8'h05;
  localparam logic [7:0] RXPD_IDX_RX_CONTROL    = 8'h06;
  localparam logic [7:0] RXPD_IDX_OPFUNC_SECOND = 8'h08;
  localparam logic [7:0] RXPD_IDX_HDR_CTRL_SEC  = 8'h33;
  localparam logic [7:0] RXPD_IDX_PREA_LEN      = 8'h34;
  localparam logic [7:0] RXPD_IDX_PREA_THRESH   = 8'h35;

  // reset values
  localparam logic [7:0] RXPD_RST_OPFUNC_SECOND = 8'h00;
  localparam logic [7:0] RXPD_RST_HDR_CTRL_SEC  = 8'h22;
  localparam logic [7:0] RXPD_RST_PREA_LEN      = 8'h07;
  localparam logic [7:0] RXPD_RST_PREA_THRESH   = 8'h20;
  localparam logic [7:0] RXPD_RST_IRQ_MASK      = 8'h00;
  localparam logic [7:0] RXPD_RST_RX_CONTROL    = 8'h00;

  // field positions
  localparam int RXPD_BIT_VALID      = 0;
  localparam int RXPD_BIT_INVALID    = 1;
  localparam int RXPD_BIT_SETTLING   = 2;
  localparam int RXPD_BIT_RX_ENABLE  = 0;
  localparam int RXPD_GPIO_SEL_LSB   = 1;
  localparam int RXPD_THRESH_LSB     = 3;
  localparam int RXPD_HDR_PREA_MSB   = 0;
  localparam int RXPD_HDR_RSVD       = 7;
  localparam int RXPD_ANTDIV_LSB     = 5;
  localparam logic [7:0] RXPD_EVENT_MASK   = 8'h03;
  localparam logic [7:0] RXPD_THRESH_MASK  = 8'hf8;
  localparam logic [7:0] RXPD_HDR_MASK     = 8'h7f;
  localparam logic [7:0] RXPD_CTRL_MASK    = 8'h07;

  // threshold step and receiver settling blank, both in bit periods
  localparam int RXPD_THRESH_STEP_BITS = 4;
  localparam int RXPD_BLANK_BITS       = 16;

  // pin selection codes
  typedef enum logic [1:0] {
    RXPD_GPIO_VALID   = 2'h0,
    RXPD_GPIO_INVALID = 2'h1,
    RXPD_GPIO_LOW     = 2'h2,
    RXPD_GPIO_HIGH    = 2'h3
  } rxpd_gpio_sel_t;

  localparam logic [1:0] RXPD_HTRANS_NONSEQ = 2'h2;

endpackage : rxpd_pkg

//--- hw/rxpd_run_counter.sv
// counter of consecutive alternating bits of the preamble pattern
`timescale 1ns/10ps
module rxpd_run_counter #(
  parameter int CW = 8
) (
  // clock and reset
  input  wire logic          hclk,
  input  wire logic          hresetn,
  // control
  input  wire logic          clear,
  input  wire logic [CW-1:0] run_need,
  // bit stream
  input  wire logic          bit_valid,
  input  wire logic          bit_data,
  // results
  output logic               run_hit,
  output logic               mismatch
);

  logic          prev_ff;
  logic          have_prev_ff;
  logic [CW-1:0] count_ff;
  logic          mismatch_ff;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      prev_ff      <= 1'b0;
      have_prev_ff <= 1'b0;
    end
    else if (clear)
    begin
      have_prev_ff <= 1'b0;
    end
    else if (bit_valid)
    begin
      prev_ff      <= bit_data;
      have_prev_ff <= 1'b1;
    end
  end

  // a run is counted as transitions between neighbouring bits
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      count_ff    <= '0;
      mismatch_ff <= 1'b0;
    end
    else if (clear)
    begin
      count_ff    <= '0;
      mismatch_ff <= 1'b0;
    end
    else if (bit_valid && have_prev_ff)
    begin
      if (bit_data != prev_ff)
      begin
        if (count_ff != '1)
        begin
          count_ff <= count_ff + 1'b1;
        end
        mismatch_ff <= 1'b0;
      end
      else
      begin
        count_ff    <= '0;
        mismatch_ff <= 1'b1;
      end
    end
    else
    begin
      mismatch_ff <= 1'b0;
    end
  end

  assign run_hit  = (run_need != '0) && (count_ff >= run_need);
  assign mismatch = mismatch_ff;

endmodule : rxpd_run_counter

//--- tb/rxpd_bit_source.sv
// behavioural demodulator bit stream and sync finder feeding the detector
`timescale 1ns/10ps
module rxpd_bit_source (
  // clock
  input wire logic hclk,
  // bit stream
  output logic     bit_valid,
  output logic     bit_data,
  output logic     sync_found
);
  initial
  begin
    bit_valid  = 1'b0;
    bit_data   = 1'b0;
    sync_found = 1'b0;
  end

  // data turns over after the strobe so a stale sample never looks like a held bit
  task automatic send_bit(input logic b, input int gap);
    @(posedge hclk);
    bit_valid <= 1'b1;
    bit_data  <= b;
    @(posedge hclk);
    bit_valid <= 1'b0;
    bit_data  <= ~b;
    repeat (gap) @(posedge hclk);
  endtask : send_bit

  task automatic send_sync;
    @(posedge hclk);
    sync_found <= 1'b1;
    @(posedge hclk);
    sync_found <= 1'b0;
  endtask : send_sync
endmodule : rxpd_bit_source

//--- tb/rxpd_detector_assertions.sv
// concurrent checks on the preamble detector ports
`timescale 1ns/10ps
module rxpd_detector_checker
  import rxpd_pkg::*;
(
  // clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // register bus
  input wire logic        hsel,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  // receive side
  input wire logic        bit_valid,
  input wire logic        preamble_detect,
  input wire logic        invalid_preamble_flag,
  input wire logic [8:0]  tx_preamble_len,
  input wire logic [2:0]  ant_div_mode
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  logic       wr_dp_ff;
  logic [2:0] since_bit_ff;
  wire        take    = hsel && hready && (htrans == RXPD_HTRANS_NONSEQ);
  wire        rd_take = take && !hwrite;

  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      wr_dp_ff <= 1'b0;
    else if (hready)
      wr_dp_ff <= take && hwrite;

  // saturating age of the last bit strobe; flags may only rise shortly after one
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      since_bit_ff <= 3'h7;
    else if (bit_valid)
      since_bit_ff <= 3'h0;
    else if (since_bit_ff != 3'h7)
      since_bit_ff <= since_bit_ff + 3'h1;

  sequence s_rd_take;
    rd_take;
  endsequence
  sequence s_one_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  AST_RD_ONE_WAIT: assert property (s_rd_take |=> s_one_wait)
    else $error("read data phase not exactly one wait state");
  AST_WAIT_ONLY_RD: assert property ($fell(hreadyout) |-> $past(rd_take))
    else $error("wait state without a read");
  AST_WR_NO_WAIT: assert property (take && hwrite |=> hreadyout)
    else $error("write data phase stalled");
  AST_RESP_OKAY: assert property (hresp == 1'b0)
    else $error("error response seen");
  AST_RD_UPPER_ZERO: assert property (hreadyout |-> hrdata[31:8] == 24'h0)
    else $error("upper read data not zero");
  AST_RD_HOLD: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
    else $error("read data changed outside a read");
  AST_CFG_BY_WRITE: assert property (
    $changed(tx_preamble_len) || $changed(ant_div_mode) |-> $past(wr_dp_ff, 2))
    else $error("configuration output changed without a write");
  AST_DET_ON_BIT: assert property ($rose(preamble_detect) |-> since_bit_ff <= 3'h4)
    else $error("detect rose away from a bit");
  AST_INV_ON_BIT: assert property ($rose(invalid_preamble_flag) |-> since_bit_ff <= 3'h4)
    else $error("invalid flag rose away from a bit");
endmodule : rxpd_detector_checker

bind rxpd_detector rxpd_detector_checker u_chk (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
  .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
  .bit_valid(bit_valid), .preamble_detect(preamble_detect),
  .invalid_preamble_flag(invalid_preamble_flag), .tx_preamble_len(tx_preamble_len),
  .ant_div_mode(ant_div_mode)
);

//--- tb/rxpd_detector_tb.sv
// self-checking bench for the receive preamble detector
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %h got %h", nm, (e), (g)); end end
module rxpd_detector_tb
  import rxpd_pkg::*;
;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, rd_dp, b;
  logic        gpio_out, irq, preamble_detect, invalid_preamble_flag;
  logic        bit_valid, bit_data, sync_found;
  logic [1:0]  htrans;
  logic [2:0]  hsize, ant_div_mode;
  logic [7:0]  r, q_e;
  logic [8:0]  tx_preamble_len;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  exp_q[$];
  int          err_total, check_count, need;
  localparam logic [7:0] RST_IDX [9] = '{RXPD_IDX_STATUS_FIRST, RXPD_IDX_STATUS_SECOND,
    RXPD_IDX_IRQ_MASK, RXPD_IDX_RX_CONTROL, RXPD_IDX_OPFUNC_SECOND, RXPD_IDX_HDR_CTRL_SEC,
    RXPD_IDX_PREA_LEN, RXPD_IDX_PREA_THRESH, 8'h01};
  localparam logic [7:0] RST_VAL [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h22, 8'h07,
    8'h20, 8'h00};

  assign hready = hreadyout;

  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  rxpd_detector #(.SYNC_WAIT_BITS(4)) uut (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .bit_valid(bit_valid),
    .bit_data(bit_data), .sync_found(sync_found), .gpio_out(gpio_out), .irq(irq),
    .preamble_detect(preamble_detect), .invalid_preamble_flag(invalid_preamble_flag),
    .tx_preamble_len(tx_preamble_len), .ant_div_mode(ant_div_mode)
  );
  rxpd_bit_source src (
    .hclk(hclk), .bit_valid(bit_valid), .bit_data(bit_data), .sync_found(sync_found)
  );

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : tally_and_finish

  // single word transfer; a read notes its expected byte for the monitor
  task automatic ahb(input logic wr, input logic [7:0] idx, input logic [7:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= RXPD_HTRANS_NONSEQ;
    hwrite <= wr;
    if (!wr)
      exp_q.push_back(d);
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge hclk); while (hready !== 1'b1);
  endtask : ahb

  task automatic settle;
    repeat (3) @(posedge hclk);
  endtask : settle

  // bit gap varies so the detector sees both quick and slow streams
  task automatic put(input logic v);
    src.send_bit(v, 4 + $urandom_range(3));
  endtask : put

  always @(posedge hclk)
  begin
    if (rd_dp && hready === 1'b1)
    begin
      q_e = exp_q.pop_front();
      `CHK("hrdata", {24'h0, q_e}, hrdata)
    end
    if (hready === 1'b1)
      rd_dp = hsel && htrans == RXPD_HTRANS_NONSEQ && !hwrite;
  end

  initial
  begin
    repeat (20000) @(posedge hclk);
    err_total++;
    tally_and_finish();
  end

  initial
  begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    rd_dp = 1'b0;
    err_total = 0;
    check_count = 0;
    void'($urandom(32'h1f48));
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    `CHK("txlen_rst", 9'h007, tx_preamble_len)
    for (int i = 0; i < 9; i++)
      ahb(1'b0, RST_IDX[i], RST_VAL[i]);
    r = 8'($urandom);
    ahb(1'b1, RXPD_IDX_OPFUNC_SECOND, r);
    ahb(1'b0, RXPD_IDX_OPFUNC_SECOND, r);
    settle();
    `CHK("antdiv", r[7:5], ant_div_mode)
    ahb(1'b1, RXPD_IDX_HDR_CTRL_SEC, 8'hff);
    ahb(1'b1, RXPD_IDX_PREA_LEN, 8'hff);
    ahb(1'b0, RXPD_IDX_HDR_CTRL_SEC, 8'h7f);
    ahb(1'b1, RXPD_IDX_PREA_THRESH, 8'hff);
    ahb(1'b0, RXPD_IDX_PREA_THRESH, 8'hf8);
    ahb(1'b1, 8'h01, 8'hff);
    ahb(1'b0, 8'h01, 8'h00);
    ahb(1'b1, RXPD_IDX_STATUS_SECOND, 8'hff);
    ahb(1'b0, RXPD_IDX_STATUS_SECOND, 8'h00);
    settle();
    `CHK("txlen", 9'h1ff, tx_preamble_len)
    ahb(1'b1, RXPD_IDX_OPFUNC_SECOND, 8'h00);
    for (int s = 0; s < 4; s++)
    begin
      ahb(1'b1, RXPD_IDX_RX_CONTROL, 8'(s << 1));
      settle();
      `CHK("gpio_sel", s == 3, gpio_out)
    end
    need = 4 * (1 + $urandom_range(2));
    ahb(1'b1, RXPD_IDX_PREA_THRESH, 8'(need << 1));
    ahb(1'b1, RXPD_IDX_IRQ_MASK, RXPD_EVENT_MASK);
    ahb(1'b1, RXPD_IDX_RX_CONTROL, 8'h01);
    ahb(1'b0, RXPD_IDX_STATUS_SECOND, 8'h04);
    // equal bits: blanked while settling, an error once searching
    for (int i = 0; i < RXPD_BLANK_BITS + 2; i++)
    begin
      put(1'b0);
      if (i < RXPD_BLANK_BITS - 1)
        `CHK("inv_blank", 1'b0, invalid_preamble_flag)
    end
    settle();
    `CHK("inv", 1'b1, invalid_preamble_flag)
    `CHK("irq_inv", 1'b1, irq)
    ahb(1'b0, RXPD_IDX_STATUS_SECOND, 8'h02);
    ahb(1'b1, RXPD_IDX_RX_CONTROL, 8'h03);
    settle();
    `CHK("gpio_inv", 1'b1, gpio_out)
    ahb(1'b1, RXPD_IDX_RX_CONTROL, 8'h01);
    b = 1'b1;
    for (int i = 1; i <= need; i++)
    begin
      put(b);
      b = ~b;
      `CHK("det", i == need, preamble_detect)
    end
    settle();
    `CHK("gpio_det", 1'b1, gpio_out)
    ahb(1'b0, RXPD_IDX_STATUS_SECOND, 8'h01);
    ahb(1'b0, RXPD_IDX_STATUS_FIRST, 8'h03);
    for (int i = 1; i <= 4; i++)
    begin
      put(b);
      b = ~b;
      `CHK("det_wait", i < 4, preamble_detect)
    end
    repeat (need + 1)
    begin
      put(b);
      b = ~b;
    end
    `CHK("det_again", 1'b1, preamble_detect)
    src.send_sync();
    repeat (6) put(b);
    `CHK("det_lock", 1'b1, preamble_detect)
    ahb(1'b1, RXPD_IDX_IRQ_MASK, 8'h00);
    settle();
    `CHK("irq_mask", 1'b0, irq)
    ahb(1'b1, RXPD_IDX_IRQ_MASK, 8'h02);
    settle();
    `CHK("irq_unmask", 1'b1, irq)
    ahb(1'b1, RXPD_IDX_STATUS_FIRST, 8'h03);
    ahb(1'b0, RXPD_IDX_STATUS_FIRST, 8'h00);
    settle();
    `CHK("irq_clr", 1'b0, irq)
    ahb(1'b1, RXPD_IDX_RX_CONTROL, 8'h00);
    settle();
    `CHK("det_off", 1'b0, preamble_detect)
    tally_and_finish();
  end
endmodule : rxpd_detector_tb
